// File: logic/apr_consts.svh
// apr_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from any apr file that needs a constant
`ifndef APR_CONSTS_SVH
`define APR_CONSTS_SVH

// register byte offsets on the wishbone port
`define APR_OFF_CFG          5'h00
`define APR_OFF_CTL          5'h04
`define APR_OFF_STAT         5'h08
`define APR_OFF_PORT         5'h0C
`define APR_OFF_DIR          5'h10

// field positions
`define APR_CFG_MAP_LSB      0
`define APR_CFG_MAP_MSB      3
`define APR_CFG_VREF_LSB     4
`define APR_CFG_VREF_MSB     5
`define APR_CTL_CLK_LSB      0
`define APR_CTL_CLK_MSB      2
`define APR_CTL_CHAN_LSB     4
`define APR_CTL_CHAN_MSB     7
`define APR_CTL_GO_BIT       8
`define APR_STAT_BUSY_BIT    0
`define APR_STAT_DONE_BIT    1
`define APR_STAT_CNT_LSB     4
`define APR_STAT_CNT_MSB     7

// reset values
`define APR_CFG_RST          6'h00
`define APR_CTL_RST          7'h00
`define APR_DIR_RST          12'hFFF

// pin map and sequencing
`define APR_NUM_PINS         12
`define APR_MAP_FIRST_DIG    4'h4
`define APR_BITS_PER_CONV    4'hC
`define APR_RC_CODE          2'h3

// timing
`define APR_CLK_PERIOD_NS    50
`define APR_RC_TAD_NS        4000
`define APR_RC_TAD_CYC       (`APR_RC_TAD_NS / `APR_CLK_PERIOD_NS)

`endif

// File: logic/apr_pkg.sv
// apr_pkg: types shared by the converter configuration block
// assumes: compiled before every apr module
package apr_pkg;

    typedef enum logic [1:0] {
        APR_IDLE   = 2'b00,
        APR_CONV   = 2'b01,
        APR_FINISH = 2'b11
    } apr_state_e;

    typedef struct packed {
        logic [1:0] reference_select;
        logic [3:0] pin_analog_map;
    } apr_cfg_s;

    typedef struct packed {
        logic [3:0] channel_select;
        logic [2:0] conversion_clock_select;
    } apr_ctl_s;

endpackage

// File: logic/apr_tad_gen.sv
// apr_tad_gen: conversion bit time strobe from the oscillator or rc timing
// assumes: run_i and sel_i come from flops on clk_i; sel_i is held while running
`timescale 1ns/1ps
`include "apr_consts.svh"
module apr_tad_gen
    import apr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    localparam logic [6:0] RC_LAST = 7'(`APR_RC_TAD_CYC - 1);

    logic [6:0] cnt_r;
    logic [6:0] last;
    logic [2:0] expo;
    logic       rc_sel;
    logic [6:0] gap_r;

    assign rc_sel = (sel_i[1:0] == `APR_RC_CODE);
    assign expo   = {sel_i[1:0], sel_i[2]};
    // rc source gives a four microsecond bit time
    assign last   = rc_sel ? RC_LAST : 7'((8'h02 << expo) - 8'h01);
    assign tick_o = run_i && (cnt_r == last);

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || tick_o) begin
            cnt_r <= 7'h00;
        end else begin
            cnt_r <= cnt_r + 7'h01;
        end
    end

    // gap since last strobe, for checking only
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || tick_o) begin
            gap_r <= 7'h00;
        end else begin
            gap_r <= gap_r + 7'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_fast_run;
        (tick_o && sel_i == 3'h0) ##1 (run_i && sel_i == 3'h0) [*2];
    endsequence

    a_div_two_gap: assert property (s_fast_run |-> tick_o && !$past(tick_o))
        else $error("divide-by-2 bit time wrong");
    a_div_sixtyfour: assert property (tick_o && sel_i == 3'h6 |-> gap_r == 7'h3F)
        else $error("divide-by-64 bit time wrong");
    a_rc_bit_time: assert property (tick_o && rc_sel |-> gap_r == RC_LAST)
        else $error("rc bit time is not four microseconds");
endmodule

// File: logic/apr_pin_cell.sv
// apr_pin_cell: analog or digital assignment and port read for one input pin
// assumes: pin_i already synchronised to clk_i
`timescale 1ns/1ps
`include "apr_consts.svh"
module apr_pin_cell
    import apr_pkg::*;
#(
    parameter int IDX = 0
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] map_i,
    input  wire logic       pin_i,
    output logic            digital_o,
    output logic            port_bit_o
);
    localparam logic [4:0] THRESH = 5'(15 - IDX);

    // codes from four upward turn pins digital from the top channel down
    assign digital_o  = (map_i >= `APR_MAP_FIRST_DIG) && ({1'b0, map_i} >= THRESH);
    // analog pins read back as zero
    assign port_bit_o = digital_o && pin_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_low_codes_analog: assert property (map_i < 4'h4 |-> !digital_o)
        else $error("low map code made a pin digital");
    a_all_digital: assert property (map_i == 4'hF |-> digital_o)
        else $error("code 1111 left a pin analog");
    a_analog_reads_zero: assert property (!digital_o |-> !port_bit_o)
        else $error("analog pin read as one");
endmodule

// File: logic/apr_conv_cfg.sv
// apr_conv_cfg: converter reference, pin map and conversion clock control
// assumes: classic wishbone master on clk_i; pins asynchronous to clk_i
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "apr_consts.svh"
module apr_conv_cfg
    import apr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [11:0] pin_i,
    output logic             vref_pos_ext_o,
    output logic             vref_neg_ext_o,
    output logic      [11:0] pin_digital_o,
    output logic      [3:0]  sample_chan_o,
    output logic             sample_from_driver_o,
    output logic             conv_busy_o,
    output logic             bit_tick_o,
    output logic             conv_done_o
);
    apr_cfg_s    cfg_r;
    apr_ctl_s    ctl_r;
    logic [11:0] dir_r;
    logic [11:0] pin_meta_r;
    logic [11:0] pin_sync_r;
    apr_state_e  state_r;
    apr_state_e  state_nxt;
    logic [3:0]  bit_cnt_r;
    logic [2:0]  run_clk_r;
    logic        done_flag_r;
    logic        tick;
    logic [11:0] digital;
    logic [11:0] port_bits;
    logic        bus_req;
    logic [4:0]  word_adr;
    logic        wr_cfg;
    logic        wr_ctl;
    logic        wr_stat;
    logic        wr_dir;
    logic        go;
    logic        last_bit;
    logic [31:0] rd_data;
    logic [3:0]  tick_seen_r;

    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign word_adr = {wb_adr_i[4:2], 2'b00};
    assign wr_cfg   = bus_req && wb_we_i && word_adr == `APR_OFF_CFG;
    assign wr_ctl   = bus_req && wb_we_i && word_adr == `APR_OFF_CTL;
    assign wr_stat  = bus_req && wb_we_i && word_adr == `APR_OFF_STAT;
    assign wr_dir   = bus_req && wb_we_i && word_adr == `APR_OFF_DIR;
    assign go       = wr_ctl && wb_sel_i[1] && wb_dat_i[`APR_CTL_GO_BIT]
                      && state_r == APR_IDLE;
    assign last_bit = tick && bit_cnt_r == `APR_BITS_PER_CONV - 4'h1;

    // pins pass two flops before any logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_r <= 12'h000;
            pin_sync_r <= 12'h000;
        end else begin
            pin_meta_r <= pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // configuration register, reset to zero, plain read/write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= `APR_CFG_RST;
        end else if (wr_cfg && wb_sel_i[0]) begin
            cfg_r <= wb_dat_i[`APR_CFG_VREF_MSB:`APR_CFG_MAP_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r <= `APR_CTL_RST;
        end else if (wr_ctl && wb_sel_i[0]) begin
            ctl_r.channel_select          <= wb_dat_i[`APR_CTL_CHAN_MSB:`APR_CTL_CHAN_LSB];
            ctl_r.conversion_clock_select <= wb_dat_i[`APR_CTL_CLK_MSB:`APR_CTL_CLK_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_r <= `APR_DIR_RST;
        end else if (wr_dir) begin
            if (wb_sel_i[0]) begin
                dir_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                dir_r[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    // per-pin assignment and port read
    genvar gi;
    generate
        for (gi = 0; gi < `APR_NUM_PINS; gi = gi + 1) begin : g_pin
            apr_pin_cell #(
                .IDX        (gi)
            ) u_cell (
                .clk_i      (clk_i),
                .rst_i      (rst_i),
                .map_i      (cfg_r.pin_analog_map),
                .pin_i      (pin_sync_r[gi]),
                .digital_o  (digital[gi]),
                .port_bit_o (port_bits[gi])
            );
        end
    endgenerate

    apr_tad_gen u_tad (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (state_r == APR_CONV),
        .sel_i  (run_clk_r),
        .tick_o (tick)
    );

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            APR_IDLE: begin
                if (go) begin
                    state_nxt = APR_CONV;
                end
            end
            APR_CONV: begin
                if (last_bit) begin
                    state_nxt = APR_FINISH;
                end
            end
            APR_FINISH: begin
                state_nxt = APR_IDLE;
            end
            default: begin
                state_nxt = APR_IDLE;
            end
        endcase
    end

    // start depends on no channel or direction bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= APR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // clock select latched at start so a rewrite cannot stretch a conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_clk_r <= 3'h0;
        end else if (go) begin
            run_clk_r <= ctl_r.conversion_clock_select;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || go) begin
            bit_cnt_r <= 4'h0;
        end else if (state_r == APR_CONV && tick) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // done flag: set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_flag_r <= 1'b0;
        end else if (last_bit) begin
            done_flag_r <= 1'b1;
        end else if (wr_stat && wb_sel_i[0] && wb_dat_i[`APR_STAT_DONE_BIT]) begin
            done_flag_r <= 1'b0;
        end
    end

    // registered outputs to the analog side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vref_pos_ext_o       <= 1'b0;
            vref_neg_ext_o       <= 1'b0;
            pin_digital_o        <= 12'h000;
            sample_chan_o        <= 4'h0;
            sample_from_driver_o <= 1'b0;
            conv_busy_o          <= 1'b0;
            bit_tick_o           <= 1'b0;
            conv_done_o          <= 1'b0;
        end else begin
            vref_pos_ext_o       <= cfg_r.reference_select[0];
            vref_neg_ext_o       <= cfg_r.reference_select[1];
            pin_digital_o        <= digital;
            // any selected pin is sampled, digital or not
            sample_chan_o        <= ctl_r.channel_select;
            // output pin converts its own driven level
            sample_from_driver_o <= (ctl_r.channel_select < 4'hC)
                                    && !dir_r[ctl_r.channel_select];
            conv_busy_o          <= (state_nxt == APR_CONV);
            bit_tick_o           <= tick && state_r == APR_CONV;
            conv_done_o          <= last_bit;
        end
    end

    // read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        case (word_adr)
            `APR_OFF_CFG: begin
                // top two bits read as zero
                rd_data[`APR_CFG_VREF_MSB:`APR_CFG_MAP_LSB] = cfg_r;
            end
            `APR_OFF_CTL: begin
                rd_data[`APR_CTL_CHAN_MSB:`APR_CTL_CHAN_LSB] = ctl_r.channel_select;
                rd_data[`APR_CTL_CLK_MSB:`APR_CTL_CLK_LSB]   = ctl_r.conversion_clock_select;
            end
            `APR_OFF_STAT: begin
                rd_data[`APR_STAT_BUSY_BIT]                    = (state_r == APR_CONV);
                rd_data[`APR_STAT_DONE_BIT]                    = done_flag_r;
                rd_data[`APR_STAT_CNT_MSB:`APR_STAT_CNT_LSB]   = bit_cnt_r;
            end
            `APR_OFF_PORT: begin
                rd_data[11:0] = port_bits;
            end
            `APR_OFF_DIR: begin
                rd_data[11:0] = dir_r;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
        end
    end

    // ticks seen in the current conversion, for checking only
    always_ff @(posedge clk_i) begin
        if (rst_i || go) begin
            tick_seen_r <= 4'h0;
        end else if (tick && state_r == APR_CONV) begin
            tick_seen_r <= tick_seen_r + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_cfg_write;
        wr_cfg && wb_sel_i[0];
    endsequence

    a_vref_follow: assert property (s_cfg_write |-> ##2
        vref_pos_ext_o == $past(wb_dat_i[4], 2) && vref_neg_ext_o == $past(wb_dat_i[5], 2))
        else $error("reference outputs do not follow the written field");
    a_top_bits_zero: assert property ($past(bus_req && word_adr == `APR_OFF_CFG)
        |-> wb_dat_o[7:6] == 2'b00)
        else $error("unimplemented config bits read as one");
    a_twelve_bits: assert property (conv_done_o |-> tick_seen_r == 4'hC)
        else $error("conversion did not take twelve bit times");
    a_start_any_chan: assert property (go |=> conv_busy_o [*2])
        else $error("conversion did not start");
    a_driver_sample: assert property (##1 $stable(ctl_r) && $stable(dir_r) &&
        ctl_r.channel_select < 4'hC |-> sample_from_driver_o == !dir_r[ctl_r.channel_select])
        else $error("output pin not sampled from its driver");
    a_cfg_reset_zero: assert property ($past(rst_i) |-> cfg_r == 6'h00)
        else $error("config register not zero after reset");
    a_map_to_pins: assert property (##1 $stable(cfg_r) |->
        pin_digital_o == digital)
        else $error("pin assignment output lags the map");
    a_digital_conv: assert property (go && digital[ctl_r.channel_select[3:0] % 12]
        |=> conv_busy_o)
        else $error("digital pin not converted");

    // bus handshake and plain read/write
    a_ack_follows_req: assert property (bus_req |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held for more than one cycle");
    a_cfg_write_lands: assert property (s_cfg_write |=>
        cfg_r == $past(wb_dat_i[`APR_CFG_VREF_MSB:`APR_CFG_MAP_LSB]))
        else $error("config write did not land");

    // conversion end: busy falls, done flag sets, pulses last one cycle
    sequence s_conv_end;
        last_bit ##1 conv_done_o;
    endsequence

    a_busy_drops_done: assert property (s_conv_end |-> !conv_busy_o)
        else $error("busy still high when conversion ended");
    a_done_flag_set: assert property (s_conv_end |-> done_flag_r)
        else $error("done flag not set at conversion end");
    a_done_flag_clear: assert property (wr_stat && wb_sel_i[0]
        && wb_dat_i[`APR_STAT_DONE_BIT] && !last_bit |=> !done_flag_r)
        else $error("done flag not cleared by write");
    a_done_pulse: assert property (conv_done_o |=> !conv_done_o)
        else $error("conversion end held for more than one cycle");
    a_tick_gap: assert property (bit_tick_o |=> !bit_tick_o)
        else $error("bit time shorter than two oscillator periods");
    a_clk_sel_held: assert property (state_r == APR_CONV ##1 state_r == APR_CONV
        |-> $stable(run_clk_r))
        else $error("clock select changed during conversion");
endmodule

// File: tb/apr_conv_cfg_tb.sv
// apr_conv_cfg_tb: self-checking bench for the converter configuration block
// assumes: apr_pkg and apr_consts.svh from logic/; bench is the wishbone master
`timescale 1ns/1ps
`include "apr_consts.svh"
module apr_conv_cfg_tb;
    import apr_pkg::*;

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [4:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [11:0] pin_i;
    logic        vref_pos_ext_o;
    logic        vref_neg_ext_o;
    logic [11:0] pin_digital_o;
    logic [3:0]  sample_chan_o;
    logic        sample_from_driver_o;
    logic        conv_busy_o;
    logic        bit_tick_o;
    logic        conv_done_o;
    int          fail_count;
    int          samples_checked;

    apr_conv_cfg uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
        .vref_pos_ext_o(vref_pos_ext_o), .vref_neg_ext_o(vref_neg_ext_o),
        .pin_digital_o(pin_digital_o), .sample_chan_o(sample_chan_o),
        .sample_from_driver_o(sample_from_driver_o), .conv_busy_o(conv_busy_o),
        .bit_tick_o(bit_tick_o), .conv_done_o(conv_done_o));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wb_xfer(input logic we, input logic [4:0] adr, input logic [3:0] sel,
                           input logic [31:0] dat, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        chk_bit(wb_ack_o, 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wb_wr(input logic [4:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] rd;
        wb_xfer(1'b1, adr, sel, dat, rd);
    endtask

    task automatic wb_rd(input logic [4:0] adr, output logic [31:0] rd);
        wb_xfer(1'b0, adr, 4'hF, 32'h0, rd);
    endtask

    task automatic t_reset;
        logic [31:0] rd;
        wb_rd(`APR_OFF_CFG, rd);
        chk_reg(rd, 32'h0);
        wb_rd(`APR_OFF_DIR, rd);
        chk_reg(rd, 32'h0000_0FFF);
        chk_reg({20'h0, pin_digital_o}, 32'h0);
        chk_bit(vref_pos_ext_o | vref_neg_ext_o, 1'b0);
    endtask

    task automatic t_reference;
        logic [31:0] rd;
        for (int c = 0; c < 4; c++) begin
            wb_wr(`APR_OFF_CFG, 32'hC0 | (c << 4), 4'h1);
            wb_rd(`APR_OFF_CFG, rd);
            chk_reg(rd, 32'(c << 4));
            chk_bit(vref_pos_ext_o, c[0]);
            chk_bit(vref_neg_ext_o, c[1]);
        end
    endtask

    task automatic t_pin_map;
        logic [31:0] rd;
        logic [11:0] mask;
        for (int m = 0; m < 16; m++) begin
            mask = (m < 4) ? 12'h000 : ~(12'hFFF >> (m - 3));
            wb_wr(`APR_OFF_CFG, 32'(m), 4'h1);
            wb_rd(`APR_OFF_PORT, rd);
            chk_reg({20'h0, pin_digital_o}, {20'h0, mask});
            chk_reg(rd, {20'h0, mask});
        end
        // digital pins follow the synchronised pin level
        pin_i <= 12'hA5A;
        repeat (2) @(posedge clk_i);
        wb_rd(`APR_OFF_PORT, rd);
        chk_reg(rd, 32'h0000_0A5A);
        pin_i <= 12'hFFF;
    endtask

    task automatic t_conv(input logic [2:0] code, input int n_exp);
        int last;
        int ticks;
        int cyc;
        logic [31:0] rd;
        wb_wr(`APR_OFF_CTL, {29'h0, code}, 4'h1);
        wb_wr(`APR_OFF_CTL, 32'h100 | code, 4'h3);
        last = -1;
        ticks = 0;
        for (cyc = 0; cyc < 2000 && conv_done_o !== 1'b1; cyc++) begin
            @(posedge clk_i);
            if (bit_tick_o === 1'b1) begin
                if (last >= 0) chk_reg(32'(cyc - last), 32'(n_exp));
                // busy falls at the edge that shows the twelfth tick
                chk_bit(conv_busy_o, 1'(ticks < 11));
                last = cyc;
                ticks++;
            end
        end
        chk_reg(32'(ticks), 32'd12);
        chk_bit(conv_done_o, 1'b1);
        chk_bit(conv_busy_o, 1'b0);
        wb_rd(`APR_OFF_STAT, rd);
        chk_bit(rd[`APR_STAT_DONE_BIT], 1'b1);
        wb_wr(`APR_OFF_STAT, 32'h2, 4'h1);
    endtask

    task automatic t_clock_codes;
        logic [2:0] codes [8] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011, 3'b111};
        int         lens  [8] = '{2, 4, 8, 16, 32, 64, 80, 80};
        for (int i = 0; i < 8; i++) begin
            t_conv(codes[i], lens[i]);
        end
    endtask

    task automatic t_driven_pin;
        logic [31:0] rd;
        wb_wr(`APR_OFF_CFG, 32'h0F, 4'h1);
        wb_wr(`APR_OFF_DIR, 32'hFFE, 4'h3);
        wb_wr(`APR_OFF_CTL, 32'h00, 4'h1);
        wb_rd(`APR_OFF_CTL, rd);
        chk_bit(sample_from_driver_o, 1'b1);
        wb_wr(`APR_OFF_CTL, 32'h10, 4'h1);
        wb_rd(`APR_OFF_CTL, rd);
        chk_reg(rd, 32'h10);
        chk_reg({28'h0, sample_chan_o}, 32'h1);
        chk_bit(sample_from_driver_o, 1'b0);
        wb_wr(`APR_OFF_CTL, 32'hC0, 4'h1);
        wb_rd(`APR_OFF_CTL, rd);
        chk_bit(sample_from_driver_o, 1'b0);
        wb_wr(`APR_OFF_CTL, 32'h00, 4'h1);
        t_conv(3'b010, 32);
    endtask

    task automatic t_unmapped;
        logic [31:0] rd;
        wb_wr(5'h14, 32'hFFFF_FFFF, 4'hF);
        wb_rd(5'h14, rd);
        chk_reg(rd, 32'h0);
        wb_rd(`APR_OFF_CFG, rd);
        chk_reg(rd, 32'h0F);
    endtask

    task automatic print_verdict;
        $display("checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end

    initial begin
        fail_count = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 5'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        pin_i = 12'hFFF;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_reference();
        t_pin_map();
        t_clock_codes();
        t_driven_pin();
        t_unmapped();
        print_verdict();
    end
endmodule
